/* src/dbs_pkg.sv */
/*
  Shared constants, types and helpers of the dual regulator enable sequencer.
  Assumes a 10 MHz core clock; all cycle counts below are derived from it.
*/
package dbs_pkg;

  localparam int CLK_PERIOD_NS = 100;

  // Time base of the four-bit delay codes
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;

  // Short-circuit qualification time
  localparam int SHORT_TIME_US = 1000;
  localparam int SHORT_CYCLES = SHORT_TIME_US * 1000 / CLK_PERIOD_NS;

  // Duration of the one-time-programmed value load after a reset
  localparam int LOAD_TIME_US = 10;
  localparam int LOAD_CYCLES = LOAD_TIME_US * 1000 / CLK_PERIOD_NS;

  // Time per voltage code step at the fastest ramp code
  localparam int RAMP_BASE_NS = 1000;
  localparam int RAMP_BASE_CYCLES = RAMP_BASE_NS / CLK_PERIOD_NS;

  localparam int CNT_W = 24;
  localparam logic [3:0] DELAY_NONE = 4'h0;
  localparam logic [7:0] VOLT_ZERO = 8'h00;
  localparam logic RESET_PENDING_INIT = 1'b1;

  typedef enum logic [1:0] {MODE_LOCKOUT, MODE_LOAD, MODE_STANDBY, MODE_ACTIVE} dbs_mode_t;
  typedef enum logic [1:0] {RG_OFF, RG_SOFT, RG_RAMP, RG_ON} dbs_reg_t;

  // Cycles between voltage code steps; each code halves the slew rate
  function automatic logic [15:0] rampInterval(input logic [2:0] code);
    return 16'(RAMP_BASE_CYCLES) << code;
  endfunction

endpackage

/* src/dbs_delay_chan.sv */
/*
  One sequenced enable channel: register control or delayed enable pin control.
  Assumes pin edges arrive as one-cycle pulses and tick as a one-cycle time base.
*/
`timescale 1ns/10ps
module dbs_delay_chan (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  input wire logic clear,
  // Control
  input wire logic onBit,
  input wire logic pinCtrl,
  input wire logic [3:0] riseDelay,
  input wire logic [3:0] fallDelay,
  // Enable pin and time base
  input wire logic pinLevel,
  input wire logic pinRise,
  input wire logic pinFall,
  input wire logic tick,
  // Request
  output logic reqOn
);

  logic pendQ;
  logic targetQ;
  logic [3:0] leftQ;

  // First tick of a delay may be partial, so a code of N waits N-1 to N ticks
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pendQ <= 1'b0;
      targetQ <= 1'b0;
      leftQ <= dbs_pkg::DELAY_NONE;
      reqOn <= 1'b0;
    end else if (clear || !onBit) begin
      pendQ <= 1'b0;
      targetQ <= 1'b0;
      leftQ <= dbs_pkg::DELAY_NONE;
      reqOn <= 1'b0;
    end else if (!pinCtrl) begin
      pendQ <= 1'b0;
      reqOn <= 1'b1;
    end else if (pinRise) begin
      targetQ <= 1'b1;
      leftQ <= riseDelay;
      pendQ <= (riseDelay != dbs_pkg::DELAY_NONE);
      if (riseDelay == dbs_pkg::DELAY_NONE) begin
        reqOn <= 1'b1;
      end
    end else if (pinFall) begin
      targetQ <= 1'b0;
      leftQ <= fallDelay;
      pendQ <= (fallDelay != dbs_pkg::DELAY_NONE);
      if (fallDelay == dbs_pkg::DELAY_NONE) begin
        reqOn <= 1'b0;
      end
    end else if (pendQ) begin
      if (tick) begin
        leftQ <= 4'(leftQ - 4'h1);
        if (leftQ == 4'h1) begin
          pendQ <= 1'b0;
          reqOn <= targetQ;
        end
      end
    end else begin
      reqOn <= pinLevel;
    end
  end

endmodule

/* src/dbs_sequencer.sv */
/*
  Enable sequencer of a two-regulator power device with two general outputs,
  short-circuit supervision, power-valid flags, resets and the interrupt line.
  Assumes all inputs are synchronous to core_clk and that configuration
  inputs come from registers kept outside, reset by this block's requests.
*/
`timescale 1ns/10ps

// Summary of operation
// - Regulators start only in standby or active
// - Off, on, or follow pin per control bits
// - Pin rise waits start-up delay code
// - Pin fall waits shutdown delay code
// - Register control acts without any delay
// - Soft-start to threshold, then ramped output
// - Low output for 1 ms: off, flag
// - Valid edge sets flag unless rise-masked
// - Invalid edge sets flag unless fall-masked
// - Live validity bit per regulator
// - Window select adds overvoltage check
// - Config bit switches enable pin pulldown
// - New voltage code ramps at chosen rate
// - Fixed frequency forced during voltage change
// - General outputs follow pin with delays
// - Soft reset: all off, defaults, reload
// - Serial interface state kept on reset
// - Supply lockout: all off, defaults
// - Supply recovery: power-on reset, reload, start
// - Interrupt line low while any flag
// - Reset-indication flag at next start-up
// - Reset-indication mask latched from stored value
// - Writing 1 clears power-valid flag
module dbs_sequencer #(
  parameter int unsigned TICK_CYCLES = dbs_pkg::TICK_CYCLES,
  parameter int unsigned SHORT_CYCLES = dbs_pkg::SHORT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Supply and reset requests
  input wire logic supplyLowLockout,
  input wire logic softResetTrigger,
  input wire logic resetMaskStored,
  // Enable pin
  input wire logic enablePin,
  input wire logic enablePulldownOn,
  // Regulator control
  input wire logic [1:0] regulatorOnBit,
  input wire logic [1:0] regulatorPinControlBit,
  input wire logic [1:0][3:0] regulatorStartupDelay,
  input wire logic [1:0][3:0] regulatorShutdownDelay,
  input wire logic [1:0][7:0] regulatorVoltageCode,
  input wire logic [1:0][2:0] rampRateCode,
  input wire logic [1:0] fixedFrequencyForce,
  // General outputs control, index 0 is output a
  input wire logic [1:0] generalOutputOnBit,
  input wire logic [1:0] generalOutputPinControl,
  input wire logic [1:0][3:0] generalOutputRiseDelay,
  input wire logic [1:0][3:0] generalOutputFallDelay,
  // Validity configuration
  input wire logic validityWindowSelect,
  input wire logic [1:0] powerValidRiseMask,
  input wire logic [1:0] powerValidFallMask,
  // Analog monitors
  input wire logic [1:0] aboveSoftStart,
  input wire logic [1:0] underVoltOk,
  input wire logic [1:0] overVoltOk,
  // Flag clears, write-one pulses
  input wire logic [1:0] shortCircuitClear,
  input wire logic [1:0] powerValidClear,
  input wire logic resetFlagClear,
  // Regulator drive
  output logic [1:0] regulatorRun,
  output logic [1:0] softStartOn,
  output logic [1:0][7:0] outputCode,
  output logic [1:0] fixedFreqMode,
  // General outputs and pin control
  output logic generalOutputA,
  output logic generalOutputB,
  output logic enablePulldown,
  // Status and flags
  output logic [1:0] powerValidLive,
  output logic [1:0] shortCircuitFlag,
  output logic [1:0] powerValidFlag,
  output logic resetIndFlag,
  output logic irqLineN,
  output logic deviceReady,
  output logic otpLoadBusy
);

  logic [1:0] rstSyncQ;
  logic rstN;
  dbs_pkg::dbs_mode_t modeQ;
  logic [15:0] loadCntQ;
  logic loadDone;
  logic wipe;
  logic allowRun;
  logic enPinQ;
  logic pinRise;
  logic pinFall;
  logic [dbs_pkg::CNT_W-1:0] tickCntQ;
  logic tick;
  logic [3:0] chOn;
  logic [3:0] chPin;
  logic [3:0][3:0] chRise;
  logic [3:0][3:0] chFall;
  logic [3:0] chReq;
  logic [1:0] scHit;
  logic otpMaskQ;
  logic resetPendQ;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstSyncQ <= 2'b00;
    end else begin
      rstSyncQ <= {rstSyncQ[0], 1'b1};
    end
  end
  assign rstN = rstSyncQ[1];

  // Lockout and soft reset clear the whole sequencing state in one cycle
  assign wipe = supplyLowLockout || softResetTrigger || !allowRun;
  assign allowRun = (modeQ == dbs_pkg::MODE_STANDBY) || (modeQ == dbs_pkg::MODE_ACTIVE);
  assign loadDone = (modeQ == dbs_pkg::MODE_LOAD) && (loadCntQ == 16'(dbs_pkg::LOAD_CYCLES - 1));

  // Device operating mode; the serial interface lives outside and is never touched here
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      modeQ <= dbs_pkg::MODE_LOCKOUT;
      loadCntQ <= 16'h0000;
    end else if (supplyLowLockout) begin
      modeQ <= dbs_pkg::MODE_LOCKOUT;
      loadCntQ <= 16'h0000;
    end else begin
      case (modeQ)
        dbs_pkg::MODE_LOCKOUT: begin
          modeQ <= dbs_pkg::MODE_LOAD;
          loadCntQ <= 16'h0000;
        end
        dbs_pkg::MODE_LOAD: begin
          loadCntQ <= 16'(loadCntQ + 16'h0001);
          if (loadDone) begin
            modeQ <= dbs_pkg::MODE_STANDBY;
          end
        end
        dbs_pkg::MODE_STANDBY: begin
          loadCntQ <= 16'h0000;
          if (softResetTrigger) begin
            modeQ <= dbs_pkg::MODE_LOAD;
          end else if (|regulatorRun) begin
            modeQ <= dbs_pkg::MODE_ACTIVE;
          end
        end
        dbs_pkg::MODE_ACTIVE: begin
          loadCntQ <= 16'h0000;
          if (softResetTrigger) begin
            modeQ <= dbs_pkg::MODE_LOAD;
          end else if (!(|regulatorRun)) begin
            modeQ <= dbs_pkg::MODE_STANDBY;
          end
        end
        default: begin
          modeQ <= dbs_pkg::MODE_LOCKOUT;
          loadCntQ <= 16'h0000;
        end
      endcase
    end
  end

  // Stored mask is taken during the load so later writes cannot change it
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      otpMaskQ <= 1'b0;
    end else if (modeQ == dbs_pkg::MODE_LOAD) begin
      otpMaskQ <= resetMaskStored;
    end
  end

  // Remember a reset or fault until the next start-up completes
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      resetPendQ <= dbs_pkg::RESET_PENDING_INIT;
    end else if (supplyLowLockout || softResetTrigger || (|scHit)) begin
      resetPendQ <= 1'b1;
    end else if (loadDone) begin
      resetPendQ <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      resetIndFlag <= 1'b0;
    end else if (loadDone && resetPendQ && !otpMaskQ) begin
      resetIndFlag <= 1'b1;
    end else if (resetFlagClear) begin
      resetIndFlag <= 1'b0;
    end
  end

  // Enable pin edges and delay time base
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      enPinQ <= 1'b0;
      tickCntQ <= '0;
    end else begin
      enPinQ <= enablePin;
      if (tick || !allowRun) begin
        tickCntQ <= '0;
      end else begin
        tickCntQ <= dbs_pkg::CNT_W'(tickCntQ + 1'b1);
      end
    end
  end
  assign pinRise = enablePin && !enPinQ;
  assign pinFall = !enablePin && enPinQ;
  assign tick = (tickCntQ == dbs_pkg::CNT_W'(TICK_CYCLES - 1));

  // Channels 0 and 1 are regulators, 2 and 3 the general outputs
  assign chOn = {generalOutputOnBit, regulatorOnBit};
  assign chPin = {generalOutputPinControl, regulatorPinControlBit};
  assign chRise = {generalOutputRiseDelay, regulatorStartupDelay};
  assign chFall = {generalOutputFallDelay, regulatorShutdownDelay};

  for (genvar c = 0; c < 4; c++) begin : gChan
    dbs_delay_chan uChan (
      .clk(core_clk),
      .rstN(rstN),
      .clear(wipe),
      .onBit(chOn[c]),
      .pinCtrl(chPin[c]),
      .riseDelay(chRise[c]),
      .fallDelay(chFall[c]),
      .pinLevel(enablePin),
      .pinRise(pinRise),
      .pinFall(pinFall),
      .tick(tick),
      .reqOn(chReq[c])
    );
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      generalOutputA <= 1'b0;
      generalOutputB <= 1'b0;
      enablePulldown <= 1'b0;
      deviceReady <= 1'b0;
      otpLoadBusy <= 1'b0;
      irqLineN <= 1'b1;
    end else begin
      generalOutputA <= chReq[2] && !wipe;
      generalOutputB <= chReq[3] && !wipe;
      enablePulldown <= enablePulldownOn;
      deviceReady <= allowRun;
      otpLoadBusy <= (modeQ == dbs_pkg::MODE_LOAD);
      irqLineN <= !((|shortCircuitFlag) || (|powerValidFlag) || resetIndFlag);
    end
  end

  for (genvar i = 0; i < 2; i++) begin : gReg
    dbs_pkg::dbs_reg_t rgQ;
    logic [dbs_pkg::CNT_W-1:0] lowCntQ;
    logic [15:0] stepCntQ;
    logic [7:0] codeQ;
    logic faultLockQ;
    logic lowTimeout;
    logic validNow;
    logic liveQ;
    logic scQ;
    logic pvQ;

    // Below threshold for the full window, both in soft-start and in operation
    assign lowTimeout = (rgQ != dbs_pkg::RG_OFF) && !aboveSoftStart[i]
                        && (lowCntQ == dbs_pkg::CNT_W'(SHORT_CYCLES - 1));
    assign scHit[i] = lowTimeout && chReq[i] && !wipe;
    assign validNow = (rgQ != dbs_pkg::RG_OFF) && underVoltOk[i]
                      && (!validityWindowSelect || overVoltOk[i]);

    always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
        rgQ <= dbs_pkg::RG_OFF;
        lowCntQ <= '0;
        stepCntQ <= 16'h0000;
        codeQ <= dbs_pkg::VOLT_ZERO;
      end else if (wipe || !chReq[i] || faultLockQ || scHit[i]) begin
        rgQ <= dbs_pkg::RG_OFF;
        lowCntQ <= '0;
        stepCntQ <= 16'h0000;
        codeQ <= dbs_pkg::VOLT_ZERO;
      end else begin
        lowCntQ <= aboveSoftStart[i] ? '0 : dbs_pkg::CNT_W'(lowCntQ + 1'b1);
        case (rgQ)
          dbs_pkg::RG_OFF: begin
            rgQ <= dbs_pkg::RG_SOFT;
          end
          dbs_pkg::RG_SOFT: begin
            if (aboveSoftStart[i]) begin
              rgQ <= dbs_pkg::RG_RAMP;
              stepCntQ <= 16'h0000;
            end
          end
          dbs_pkg::RG_RAMP: begin
            if (codeQ == regulatorVoltageCode[i]) begin
              rgQ <= dbs_pkg::RG_ON;
            end else if (stepCntQ >= 16'(dbs_pkg::rampInterval(rampRateCode[i]) - 16'h0001)) begin
              stepCntQ <= 16'h0000;
              codeQ <= (codeQ < regulatorVoltageCode[i]) ? 8'(codeQ + 8'h01) : 8'(codeQ - 8'h01);
            end else begin
              stepCntQ <= 16'(stepCntQ + 16'h0001);
            end
          end
          dbs_pkg::RG_ON: begin
            stepCntQ <= 16'h0000;
            if (codeQ != regulatorVoltageCode[i]) begin
              rgQ <= dbs_pkg::RG_RAMP;
            end
          end
          default: begin
            rgQ <= dbs_pkg::RG_OFF;
          end
        endcase
      end
    end

    // A tripped regulator stays off until its request is withdrawn
    always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
        faultLockQ <= 1'b0;
      end else if (scHit[i]) begin
        faultLockQ <= 1'b1;
      end else if (!chReq[i] || wipe) begin
        faultLockQ <= 1'b0;
      end
    end

    // Hardware sets win over a clear in the same cycle
    always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
        liveQ <= 1'b0;
        scQ <= 1'b0;
        pvQ <= 1'b0;
      end else begin
        liveQ <= validNow;
        if (wipe) begin
          scQ <= 1'b0;
        end else if (scHit[i]) begin
          scQ <= 1'b1;
        end else if (shortCircuitClear[i]) begin
          scQ <= 1'b0;
        end
        if (wipe) begin
          pvQ <= 1'b0;
        end else if ((validNow && !liveQ && !powerValidRiseMask[i])
                     || (!validNow && liveQ && !powerValidFallMask[i])) begin
          pvQ <= 1'b1;
        end else if (powerValidClear[i]) begin
          pvQ <= 1'b0;
        end
      end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
        regulatorRun[i] <= 1'b0;
        softStartOn[i] <= 1'b0;
        fixedFreqMode[i] <= 1'b0;
      end else begin
        // Gated by the request too, so a cleared enable bit stops the rail within two cycles
        regulatorRun[i] <= (rgQ != dbs_pkg::RG_OFF) && chReq[i] && !wipe;
        softStartOn[i] <= (rgQ == dbs_pkg::RG_SOFT);
        fixedFreqMode[i] <= (rgQ == dbs_pkg::RG_RAMP)
                            || (fixedFrequencyForce[i] && rgQ != dbs_pkg::RG_OFF);
      end
    end

    assign outputCode[i] = codeQ;
    assign powerValidLive[i] = liveQ;
    assign shortCircuitFlag[i] = scQ;
    assign powerValidFlag[i] = pvQ;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstN);

  chk_run_needs_mode: assert property (|regulatorRun |-> $past(allowRun))
    else $error("regulator running outside standby or active");
  chk_off_bit_clear: assert property (!regulatorOnBit[0] |-> ##2 !regulatorRun[0])
    else $error("regulator 0 still on with its enable bit clear");
  chk_soft_reset_off: assert property (softResetTrigger |=> (regulatorRun == 2'b00)
    && !generalOutputA && !generalOutputB)
    else $error("soft reset did not turn outputs off");
  chk_lockout_off: assert property (supplyLowLockout [*2] |-> (regulatorRun == 2'b00)
    && (shortCircuitFlag == 2'b00) && (powerValidFlag == 2'b00))
    else $error("lockout left outputs or flags set");
  chk_irq_follows_flag: assert property ((|shortCircuitFlag || |powerValidFlag
    || resetIndFlag) |=> !irqLineN)
    else $error("interrupt line high with a flag pending");
  chk_live_window: assert property (powerValidLive[0] == $past(gReg[0].rgQ != dbs_pkg::RG_OFF
    && underVoltOk[0] && (!validityWindowSelect || overVoltOk[0])))
    else $error("live validity did not follow the monitors");
  chk_valid_rise_flag: assert property (gReg[1].validNow && !powerValidLive[1] && !wipe
    && !powerValidRiseMask[1] |=> powerValidFlag[1])
    else $error("unmasked valid edge did not set flag");
  chk_valid_fall_flag: assert property (!gReg[0].validNow && powerValidLive[0] && !wipe
    && !powerValidFallMask[0] |=> powerValidFlag[0])
    else $error("unmasked invalid edge did not set flag");
  chk_short_trip: assert property (scHit[0] |=> shortCircuitFlag[0] ##1 !regulatorRun[0])
    else $error("short circuit did not trip regulator 0");
  chk_ramp_fixed_freq: assert property (gReg[1].rgQ == dbs_pkg::RG_RAMP && !wipe
    |=> fixedFreqMode[1])
    else $error("fixed frequency not forced during ramp");
  chk_mask_latched: assert property (loadDone && otpMaskQ |=> !$rose(resetIndFlag))
    else $error("masked reset indication raised");

endmodule

/* tb/dbs_rail_model.sv */
/*
  Behavioural model of the two regulator rails and their voltage monitors.
  Assumes regulatorRun comes from the sequencer; the bench injects faults.
*/
`timescale 1ns/10ps
module dbs_rail_model #(
  parameter int RISE_LAG = 3
) (
  // Clock
  input wire logic core_clk,
  // Regulator drive
  input wire logic [1:0] regulatorRun,
  // Fault injection
  input wire logic [1:0] shortOn,
  input wire logic [1:0] overOn,
  // Monitors
  output logic [1:0] aboveSoftStart,
  output logic [1:0] underVoltOk,
  output logic [1:0] overVoltOk
);
  logic [1:0][3:0] riseCnt;

  // A shorted rail never leaves soft-start, so the count is held at zero
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (!regulatorRun[i] || shortOn[i]) begin
        riseCnt[i] <= 4'h0;
      end else if (riseCnt[i] != 4'(RISE_LAG)) begin
        riseCnt[i] <= riseCnt[i] + 4'h1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      aboveSoftStart[i] = regulatorRun[i] && !shortOn[i] && riseCnt[i] == 4'(RISE_LAG);
    end
    underVoltOk = aboveSoftStart;
    overVoltOk = ~overOn;
  end
endmodule

/* tb/dbs_sequencer_tb.sv */
/*
  Self-checking bench of the enable sequencer with the rail model.
  Assumes short tick and short-circuit counts set by parameters below.
*/
`timescale 1ns/10ps
`define CMP(s, e, o) begin \
  tests_run++; \
  if ((o) !== (e)) begin \
    num_errors++; \
    $display("wrong value sig%0d expected %0h seen %0h", s, e, o); \
  end \
end
module dbs_sequencer_tb;
  localparam int TK = 10;
  localparam int SC = 20;
  typedef struct {int sel; logic [7:0] exp;} dbs_note_t;
  dbs_note_t q[$];
  dbs_note_t cur;
  int num_errors = 0;
  int tests_run = 0;
  int lastWait = 0;
  logic [7:0] vt;
  logic core_clk = 1'b0, nrst = 1'b0, supplyLowLockout = 1'b0, softResetTrigger = 1'b0;
  logic resetMaskStored = 1'b0, enablePin = 1'b0, enablePulldownOn = 1'b0;
  logic validityWindowSelect = 1'b0, resetFlagClear = 1'b0;
  logic [1:0] regulatorOnBit = 2'h3, regulatorPinControlBit = 2'h0, fixedFrequencyForce = 2'h0;
  logic [1:0] generalOutputOnBit = 2'h0, generalOutputPinControl = 2'h0;
  logic [1:0] powerValidRiseMask = 2'h0, powerValidFallMask = 2'h0;
  logic [1:0] shortCircuitClear = 2'h0, powerValidClear = 2'h0, shortOn = 2'h0, overOn = 2'h0;
  logic [1:0][3:0] regulatorStartupDelay = 8'h00, regulatorShutdownDelay = 8'h00;
  logic [1:0][3:0] generalOutputRiseDelay = 8'h00, generalOutputFallDelay = 8'h00;
  logic [1:0][7:0] regulatorVoltageCode = 16'h0000;
  logic [1:0][2:0] rampRateCode = 6'h00;
  logic [1:0] aboveSoftStart, underVoltOk, overVoltOk, regulatorRun, softStartOn, fixedFreqMode;
  logic [1:0] powerValidLive, shortCircuitFlag, powerValidFlag;
  logic [1:0][7:0] outputCode;
  logic generalOutputA, generalOutputB, enablePulldown, resetIndFlag, irqLineN;
  logic deviceReady, otpLoadBusy;

  dbs_sequencer #(.TICK_CYCLES(TK), .SHORT_CYCLES(SC)) i_dut (
    .core_clk, .nrst, .supplyLowLockout, .softResetTrigger, .resetMaskStored,
    .enablePin, .enablePulldownOn, .regulatorOnBit, .regulatorPinControlBit,
    .regulatorStartupDelay, .regulatorShutdownDelay, .regulatorVoltageCode,
    .rampRateCode, .fixedFrequencyForce, .generalOutputOnBit, .generalOutputPinControl,
    .generalOutputRiseDelay, .generalOutputFallDelay, .validityWindowSelect,
    .powerValidRiseMask, .powerValidFallMask, .aboveSoftStart, .underVoltOk, .overVoltOk,
    .shortCircuitClear, .powerValidClear, .resetFlagClear, .regulatorRun, .softStartOn,
    .outputCode, .fixedFreqMode, .generalOutputA, .generalOutputB, .enablePulldown,
    .powerValidLive, .shortCircuitFlag, .powerValidFlag, .resetIndFlag, .irqLineN,
    .deviceReady, .otpLoadBusy);

  dbs_rail_model i_rail (.core_clk, .regulatorRun, .shortOn, .overOn, .aboveSoftStart,
    .underVoltOk, .overVoltOk);

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [7:0] obs(input int s);
    case (s)
      0: return {6'h0, regulatorRun};
      1: return {6'h0, shortCircuitFlag};
      2: return {6'h0, powerValidFlag};
      3: return {7'h0, resetIndFlag};
      4: return {7'h0, irqLineN};
      5: return {6'h0, generalOutputB, generalOutputA};
      6: return {7'h0, enablePulldown};
      7: return {6'h0, powerValidLive};
      8: return {6'h0, fixedFreqMode};
      9: return outputCode[0];
      10: return {7'h0, deviceReady};
      12: return {6'h0, softStartOn};
      13: return {7'h0, otpLoadBusy};
      default: return lastWait[7:0];
    endcase
  endfunction

  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Expected values are queued; the monitor below settles them mid-cycle
  task automatic note(input int s, input logic [7:0] e);
    q.push_back('{s, e});
  endtask

  always @(negedge core_clk) begin
    while (q.size() > 0) begin
      cur = q.pop_front();
      `CMP(cur.sel, cur.exp, obs(cur.sel))
    end
  end

  // Bounded wait; lastWait keeps the number of extra cycles it took
  task automatic waitFor(input int s, input logic [7:0] v, input int lim);
    int n;
    n = 0;
    @(negedge core_clk);
    while (obs(s) !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    lastWait = n;
    `CMP(s, v, obs(s))
    if (obs(s) !== v) give_verdict();
    @(posedge core_clk);
  endtask

  task automatic clr(input logic [1:0] s, input logic [1:0] p, input logic r);
    shortCircuitClear <= s;
    powerValidClear <= p;
    resetFlagClear <= r;
    cyc(1);
    shortCircuitClear <= 2'h0;
    powerValidClear <= 2'h0;
    resetFlagClear <= 1'b0;
  endtask

  initial begin
    void'($urandom(99));
    vt = 8'h04 + 8'($urandom % 8);
    regulatorVoltageCode <= {vt, vt};
    cyc(12);
    nrst <= 1'b1;
    cyc(20);
    note(0, 8'h00);
    waitFor(10, 8'h01, 200);
    waitFor(0, 8'h03, 10);
    cyc(2);
    note(3, 8'h01);
    note(12, 8'h03);
    note(13, 8'h00);
    waitFor(9, 8'h01, 30);
    note(8, 8'h03);
    waitFor(9, vt, 200);
    cyc(3);
    note(8, 8'h00);
    note(2, 8'h03);
    note(7, 8'h03);
    note(4, 8'h00);
    clr(2'h0, 2'h3, 1'b1);
    cyc(2);
    note(2, 8'h00);
    note(4, 8'h01);
    // Rate code 2 gives 40 cycles a step
    regulatorVoltageCode[0] <= vt + 8'h02;
    rampRateCode[0] <= 3'h2;
    waitFor(9, vt + 8'h01, 60);
    note(8, 8'h01);
    waitFor(9, vt + 8'h02, 60);
    note(11, 8'h27);
    cyc(3);
    note(8, 8'h00);
    fixedFrequencyForce <= 2'h2;
    cyc(3);
    note(8, 8'h02);
    powerValidFallMask <= 2'h2;
    regulatorOnBit <= 2'h1;
    cyc(5);
    note(0, 8'h01);
    note(7, 8'h01);
    note(2, 8'h00);
    regulatorOnBit <= 2'h3;
    regulatorPinControlBit <= 2'h2;
    regulatorStartupDelay[1] <= 4'h2;
    regulatorShutdownDelay[1] <= 4'h2;
    powerValidRiseMask <= 2'h2;
    generalOutputOnBit <= 2'h3;
    generalOutputPinControl <= 2'h3;
    generalOutputRiseDelay <= 8'h10;
    generalOutputFallDelay <= 8'h03;
    cyc(3);
    note(0, 8'h01);
    enablePin <= 1'b1;
    cyc(8);
    note(0, 8'h01);
    waitFor(0, 8'h03, 25);
    cyc(6);
    note(5, 8'h03);
    note(2, 8'h00);
    enablePin <= 1'b0;
    cyc(3);
    enablePin <= 1'b1;
    cyc(25);
    note(0, 8'h03);
    note(5, 8'h03);
    enablePin <= 1'b0;
    cyc(8);
    note(0, 8'h03);
    note(5, 8'h01);
    waitFor(0, 8'h01, 25);
    waitFor(5, 8'h00, 35);
    enablePulldownOn <= 1'b1;
    cyc(2);
    note(6, 8'h01);
    clr(2'h0, 2'h3, 1'b0);
    shortOn <= 2'h1;
    cyc(15);
    note(1, 8'h00);
    waitFor(1, 8'h01, 15);
    cyc(2);
    note(0, 8'h00);
    note(2, 8'h01);
    regulatorOnBit[0] <= 1'b0;
    shortOn <= 2'h0;
    clr(2'h1, 2'h1, 1'b0);
    cyc(2);
    note(2, 8'h00);
    note(4, 8'h01);
    regulatorOnBit[0] <= 1'b1;
    waitFor(7, 8'h01, 30);
    overOn <= 2'h1;
    cyc(3);
    note(7, 8'h01);
    validityWindowSelect <= 1'b1;
    cyc(3);
    note(7, 8'h00);
    validityWindowSelect <= 1'b0;
    overOn <= 2'h0;
    enablePin <= 1'b1;
    waitFor(5, 8'h03, 25);
    softResetTrigger <= 1'b1;
    cyc(1);
    softResetTrigger <= 1'b0;
    cyc(2);
    note(0, 8'h00);
    note(5, 8'h00);
    note(10, 8'h00);
    note(13, 8'h01);
    waitFor(10, 8'h01, 250);
    cyc(2);
    note(3, 8'h01);
    clr(2'h0, 2'h0, 1'b1);
    // Stored mask set: the lockout restart must stay silent
    resetMaskStored <= 1'b1;
    supplyLowLockout <= 1'b1;
    enablePin <= 1'b0;
    cyc(3);
    note(0, 8'h00);
    note(5, 8'h00);
    note(10, 8'h00);
    supplyLowLockout <= 1'b0;
    waitFor(10, 8'h01, 250);
    cyc(2);
    note(3, 8'h00);
    waitFor(0, 8'h01, 25);
    cyc(2);
    give_verdict();
  end
endmodule
